// >>> bench/jrx_link_properties.sv
// concurrent checks on the lane bundle and the register handshake
`timescale 1ns/1ps
module jrx_link_properties #(parameter int LANES = 8) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [LANES-1:0][7:0] lane_octet,
    input wire logic lane_valid,
    input wire logic [1:0] sync_n,
    input wire logic [LANES-1:0][7:0] rx_octet,
    input wire logic [1:0] rx_valid,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // a fresh request always sees exactly one wait state
    sequence req_new;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence req_held;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    wait_first_a: assert property (req_new |-> avs_waitrequest) else $error("no wait state");
    wait_one_a: assert property (req_held |=> !avs_waitrequest) else $error("wait too long");
    wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
    // transmitter keeps sending the comma while the receiver holds sync low
    comma_sent_a: assert property ($past(!sync_n[0]) && lane_valid |-> lane_octet[0] == jrx_pkg::K28_5)
        else $error("no comma while sync low");
    dead_octet_a: assert property (!lane_valid |=> rx_octet == '0) else $error("octet without valid");
    link_down_a: assert property (!sync_n[0] |-> rx_octet[0] == 8'h00) else $error("octet while link down");
    // reset values seen at edges inside reset, so no disable here
    reset_rx_a: assert property (disable iff (1'b0) !resetn |-> sync_n == 2'b00 && rx_valid == 2'b00)
        else $error("rx not reset");
    reset_tx_a: assert property (disable iff (1'b0) !resetn |-> !lane_valid && lane_octet == '0)
        else $error("tx not reset");
endmodule

// >>> bench/testbench.sv
// self-checking bench: both link ends joined, receiver registers over the bus
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b1;
    logic [3:0] mode = 4'h6;
    logic scramble_en = 1'b1;
    logic sum_method = 1'b0;
    logic [2:0] subclass = 3'h1;
    logic [15:0] data_rate = 16'h0064;
    logic [7:0][7:0] sample_in = 64'h8877665544332211;
    logic sysref_req = 1'b0;
    logic [31:0] lane_rate_out;
    logic [7:0] cfg_sum_out;
    logic [12:0] avs_address = 13'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0][7:0] rx_octet;
    logic [1:0] rx_valid;
    logic [7:0] fsum;
    logic [7:0] rsum;
    int errors = 0;
    int total_checks = 0;
    // mode table rows 0-9, then four faulty rows, then mode 6 again
    int tl[15] = '{8, 8, 4, 2, 4, 4, 2, 1, 2, 1, 2, 2, 4, 3, 2};
    int tm[15] = '{4, 4, 4, 4, 2, 2, 2, 2, 1, 1, 2, 2, 2, 2, 2};
    int ts[15] = '{1, 2, 1, 1, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    int tf[15] = '{1, 2, 2, 4, 1, 2, 2, 4, 1, 2, 2, 2, 1, 2, 2};
    // ****************
    // the two ends and the checker
    // ****************
    jrx_link_if link ();
    jrx_tx i_jrx_tx (.clk, .resetn, .link(link), .mode, .dual(1'b0), .k_short(1'b0), .scramble_en,
        .sum_method, .subclass, .version(3'h1), .data_rate, .sample_in, .sample_ready(), .sysref_req,
        .lane_rate_out, .cfg_sum_out);
    jrx_rx i_jrx_rx (.clk, .resetn, .link(link), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_octet, .rx_valid);
    jrx_link_properties i_jrx_link_properties (.clk, .resetn, .lane_octet(link.lane_octet),
        .lane_valid(link.lane_valid), .sync_n(link.sync_n), .rx_octet, .rx_valid, .avs_read, .avs_write,
        .avs_waitrequest);
    always #25 clk = ~clk;
    // ****************
    // tasks
    // ****************
    task automatic test_done;
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // waitrequest and read data are both taken at the rising edge that ends the wait
    task automatic bus(input logic wr, input logic [10:0] idx, input logic [7:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        for (n = 1; n < 50 && avs_waitrequest !== 1'b0; n++) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            test_done();
        end
    endtask
    task automatic wr(input logic [10:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, 4'hF, d);
    endtask
    task automatic rd(input logic [10:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, 4'hF, d);
        check(d, {24'h000000, exp});
    endtask
    // one page of link words; both sums kept for the checksum reads
    task automatic cfg(input int r);
        logic [7:0] w [3:10];
        logic hd;
        hd = (tf[r] == 1) || (r == 10);
        w[3] = {3'h4, 5'(tl[r] - 1)};
        w[4] = 8'(tf[r] - 1);
        w[5] = (r == 12) ? 8'h0F : 8'h1F;
        w[6] = 8'(tm[r] - 1);
        w[7] = (r == 11) ? 8'h0E : 8'h0F;
        w[8] = 8'h2F;
        w[9] = {3'h1, 5'(ts[r] - 1)};
        w[10] = {hd, 7'h00};
        rsum = 8'h00;
        for (int i = 3; i <= 10; i++) begin
            wr(jrx_pkg::OFS_CFG_FIRST + 11'(i), w[i]);
            rsum = rsum + w[i];
        end
        fsum = 8'(tl[r] + tm[r] + ts[r] - 3 + hd) + w[5] + w[7] + 8'h12;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [31:0] st;
        int n;
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(jrx_pkg::OFS_PWDN, 8'h00);
        wr(jrx_pkg::OFS_PWDN, 8'hCC);
        bus(1'b1, jrx_pkg::OFS_PWDN, 8'h00, 4'h0, st);
        rd(jrx_pkg::OFS_PWDN, 8'hCC);
        wr(11'h7FF, 8'h5A);
        rd(11'h7FF, 8'h00);
        for (int r = 0; r < 15; r++) begin
            cfg(r);
            rd(jrx_pkg::OFS_CFG_ERR, (r >= 10 && r <= 13) ? 8'(1 << (r - 10)) : 8'h00);
        end
        wr(jrx_pkg::OFS_PAGE, 8'h01);
        rd(jrx_pkg::OFS_CFG_FIRST + 11'h003, 8'h00);
        wr(jrx_pkg::OFS_PAGE, 8'h00);
        rd(jrx_pkg::OFS_CFG_FIRST + 11'h003, 8'h81);
        wr(jrx_pkg::OFS_LINK_CTRL, 8'hFF);
        rd(jrx_pkg::OFS_LINK_CTRL, 8'h4B);
        rd(jrx_pkg::OFS_CFG_ERR, 8'h10);
        wr(jrx_pkg::OFS_LINK_CTRL, 8'h01);
        rd(jrx_pkg::OFS_CSUM, fsum);
        wr(jrx_pkg::OFS_LINK_CTRL, 8'h41);
        rd(jrx_pkg::OFS_CSUM, rsum);
        check(cfg_sum_out, fsum);
        sum_method <= 1'b1;
        check(lane_rate_out, 32'h14 * 32'h64 * 32'h2 / 32'h2);
        wr(jrx_pkg::OFS_LANE_EN, 8'h03);
        rd(jrx_pkg::OFS_LANE_EN, 8'h03);
        wr(jrx_pkg::OFS_LANE_DSK, 8'h03);
        wr(jrx_pkg::OFS_SUBCLASS, 8'h01);
        wr(jrx_pkg::OFS_PWDN, 8'hFC);
        wr(jrx_pkg::OFS_SYNC_CTRL, 8'h01);
        wr(jrx_pkg::OFS_SYNC_CTRL, 8'h81);
        wr(jrx_pkg::OFS_SYNC_CTRL, 8'hC1);
        sysref_req <= 1'b1;
        @(posedge clk);
        sysref_req <= 1'b0;
        st = 32'h0;
        for (n = 0; n < 20 && st[3] !== 1'b1; n++) begin
            bus(1'b0, jrx_pkg::OFS_SYNC_STAT, 8'h00, 4'hF, st);
        end
        check(st & 32'h8, 32'h8);
        check(cfg_sum_out, rsum);
        for (n = 0; n < 500 && rx_valid[0] !== 1'b1; n++) begin
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
        check(rx_valid[0], 1'b1);
        check(rx_octet[0], 8'h11);
        check(rx_octet[1], 8'h22);
        wr(jrx_pkg::OFS_PWDN, 8'hFE);
        repeat (3) @(posedge clk);
        check(rx_octet[1], 8'h00);
        test_done();
    end
endmodule

// >>> hw/jrx_link_if.sv
// serial lane bundle between the transmitter end and the receiver end
`timescale 1ns/1ps
interface jrx_link_if #(parameter int LANES = 8);
    logic [LANES-1:0][7:0] lane_octet;
    logic lane_valid;
    logic sysref;
    logic [1:0] sync_n;

    modport tx_end (output lane_octet, output lane_valid, output sysref, input sync_n);
    modport rx_end (input lane_octet, input lane_valid, input sysref, output sync_n);
endinterface

// >>> hw/jrx_pkg.sv
// shared constants, types and functions for both ends of the receive link
package jrx_pkg;
    // ******************************
    // geometry and register offsets
    // ******************************
    localparam int LANES = 8;
    localparam int CFG_WORDS = 11;
    localparam logic [10:0] OFS_SYNC_CTRL = 11'h03A;
    localparam logic [10:0] OFS_SYNC_STAT = 11'h03B;
    localparam logic [10:0] OFS_PWDN = 11'h201;
    localparam logic [10:0] OFS_LINK_CTRL = 11'h300;
    localparam logic [10:0] OFS_SUBCLASS = 11'h301;
    localparam logic [10:0] OFS_CFG_FIRST = 11'h450;
    localparam logic [10:0] OFS_CFG_LAST = 11'h45A;
    localparam logic [10:0] OFS_PAGE = 11'h460;
    localparam logic [10:0] OFS_LANE_EN = 11'h461;
    localparam logic [10:0] OFS_LANE_DSK = 11'h462;
    localparam logic [10:0] OFS_CSUM = 11'h463;
    localparam logic [10:0] OFS_LINK_RST = 11'h464;
    localparam logic [10:0] OFS_CFG_ERR = 11'h465;
    // ******************************
    // field positions and values
    // ******************************
    localparam int LC_SUM_BIT = 6;
    localparam int LC_DUAL_BIT = 3;
    localparam int SYNC_ONESHOT_BIT = 0;
    localparam int SYNC_ARM_BIT = 6;
    localparam int SYNC_EN_BIT = 7;
    localparam int STAT_LOCK_BIT = 3;
    localparam int CW_L = 3;
    localparam int CW_F = 4;
    localparam int CW_K = 5;
    localparam int CW_M = 6;
    localparam int CW_N = 7;
    localparam int CW_NP = 8;
    localparam int CW_S = 9;
    localparam int CW_HD = 10;
    localparam logic [4:0] SAMPLE_BITS = 5'd16;
    localparam logic [4:0] K_LONG = 5'd0;
    localparam logic [4:0] K_SHORT = 5'd16;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] LANE_RATE_MULT = 32'h14;

    typedef logic [CFG_WORDS-1:0][7:0] jrx_cfg_t;
    typedef struct packed {
        logic ok;
        logic [4:0] m;
        logic [4:0] l;
        logic [4:0] s;
        logic [4:0] f;
    } jrx_mode_t;

    // operating mode table; ok low for an unusable mode
    function automatic jrx_mode_t mode_params(input logic [3:0] md, input logic dual);
        jrx_mode_t p;
        p = '0;
        case (md)
            4'h0: p = '{!dual, 5'd4, 5'd8, 5'd1, 5'd1};
            4'h1: p = '{!dual, 5'd4, 5'd8, 5'd2, 5'd2};
            4'h2: p = '{!dual, 5'd4, 5'd4, 5'd1, 5'd2};
            4'h3: p = '{!dual, 5'd4, 5'd2, 5'd1, 5'd4};
            4'h4: p = '{1'b1, 5'd2, 5'd4, 5'd1, 5'd1};
            4'h5: p = '{1'b1, 5'd2, 5'd4, 5'd2, 5'd2};
            4'h6: p = '{1'b1, 5'd2, 5'd2, 5'd1, 5'd2};
            4'h7: p = '{1'b1, 5'd2, 5'd1, 5'd1, 5'd4};
            4'h9: p = '{1'b1, 5'd1, 5'd2, 5'd1, 5'd1};
            4'hA: p = '{1'b1, 5'd1, 5'd1, 5'd1, 5'd2};
            default: p = '0;
        endcase
        return p;
    endfunction

    // bit0: a table mode matches, bit1: that mode allows only 32 frames
    function automatic logic [1:0] mode_match(input logic [4:0] l, input logic [4:0] m, input logic [4:0] s,
                                              input logic [4:0] f, input logic dual);
        jrx_mode_t p;
        logic [1:0] r;
        r = 2'b00;
        for (int md = 0; md < 11; md++) begin
            p = mode_params(4'(md), dual);
            if (p.ok && p.l == l && p.m == m && p.s == s && p.f == f) begin
                r = {(md == 0 || md == 4 || md == 9), 1'b1};
            end
        end
        return r;
    endfunction

    // sum of the individual fields, all counts kept as value minus one
    function automatic logic [7:0] field_sum(input jrx_cfg_t c);
        return 8'({3'h0, c[CW_L][4:0]} + {3'h0, c[CW_M]} + {3'h0, c[CW_K][4:0]} + {3'h0, c[CW_N][4:0]}
            + {3'h0, c[CW_NP][4:0]} + {3'h0, c[CW_S][4:0]} + {7'h0, c[CW_L][7]} + {7'h0, c[CW_HD][7]}
            + {5'h0, c[CW_NP][7:5]} + {5'h0, c[CW_S][7:5]});
    endfunction

    // sum of the packed configuration words
    function automatic logic [7:0] reg_sum(input jrx_cfg_t c);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 0; i < CFG_WORDS; i++) begin
            t = 8'(t + c[i]);
        end
        return t;
    endfunction

    // self-synchronising 1 + x^14 + x^15 over one octet, msb first; descr picks the state source
    function automatic logic [22:0] scr_step(input logic [14:0] st, input logic [7:0] din, input logic descr);
        logic [14:0] s;
        logic [7:0] q;
        logic b;
        s = st;
        q = 8'h00;
        for (int j = 7; j >= 0; j--) begin
            b = din[j] ^ s[14] ^ s[13];
            q[j] = b;
            s = {s[13:0], descr ? din[j] : b};
        end
        return {s, q};
    endfunction

    // per-lane rate from input sample rate, converter count and lane count
    function automatic logic [31:0] lane_rate(input logic [15:0] rate, input logic [4:0] m, input logic [4:0] l);
        return (LANE_RATE_MULT * {16'h0000, rate} * {27'h0, m}) / ((l == 5'd0) ? 32'h1 : {27'h0, l});
    endfunction
endpackage

// >>> hw/jrx_rx.sv
// receiver end: register file, configuration check, descrambling and sync machine
// Notes on behaviour
// RULE1: modes 0-3: four converters, single link
// RULE2: modes 4-7,9,10 table, single or dual
// RULE3: high density set exactly when one octet
// RULE4: resolution and sample width both sixteen
// RULE5: modes 0,4,9 need 32 frames
// RULE6: dual link: two separately resettable links
// RULE7: software programs both link pages identically
// RULE8: transmitter mirrors all link parameters
// RULE9: scrambling setting turns descrambling on
// RULE10: page select steers configuration accesses
// RULE11: thermometer masks enable and deskew lanes
// RULE12: power-down bit turns lane off
// RULE13: sum method must match transmitter
// RULE14: field sum, low eight bits
// RULE15: register sum over 0x450..0x45A
// RULE16: lane rate = 20*rate*M/L
// RULE17: subclass decides SYSREF-based determinism
// RULE18: lock shows in status bit 3
// RULE19: activation 1 link 0, 3 both
// RULE20: counts stored as value minus one
// RULE21: sync control 0x01, 0x81, 0xC1
// RULE22: descrambler 1+x^14+x^15 per lane
`timescale 1ns/1ps
module jrx_rx #(parameter int LANES = 8) (
    input wire logic clk,
    input wire logic resetn,
    jrx_link_if.rx_end link,
    input wire logic [12:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [LANES-1:0][7:0] rx_octet,
    output logic [1:0] rx_valid
);
    // ******************************
    // avalon slave: one wait state on every access
    // ******************************
    logic ack_reg;
    logic [10:0] idx;
    logic wr_go;
    logic rd_go;
    logic [7:0] wbyte;
    assign idx = avs_address[12:2];
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_go = avs_write && ack_reg && avs_byteenable[0];
    assign rd_go = avs_read && !ack_reg;
    assign wbyte = avs_writedata[7:0];

    // ******************************
    // registers
    // ******************************
    logic [7:0] pwdn_reg;
    logic [7:0] link_ctrl_reg;
    logic [2:0] subclass_reg;
    logic [7:0] sync_ctrl_reg;
    logic page_reg;
    logic [7:0] lane_en_reg;
    logic [7:0] lane_dsk_reg;
    logic [1:0] link_rst_reg;
    jrx_pkg::jrx_cfg_t cfg_reg [2];
    logic dual;
    logic sum_method;
    logic [1:0] link_on;
    logic cfg_hit;
    logic [3:0] cfg_idx;
    assign dual = link_ctrl_reg[jrx_pkg::LC_DUAL_BIT];
    assign sum_method = link_ctrl_reg[jrx_pkg::LC_SUM_BIT];
    assign link_on[0] = link_ctrl_reg[0]; // RULE19
    assign link_on[1] = link_ctrl_reg[1] && dual; // RULE19 RULE6
    assign cfg_hit = idx >= jrx_pkg::OFS_CFG_FIRST && idx <= jrx_pkg::OFS_CFG_LAST;
    assign cfg_idx = 4'(idx - jrx_pkg::OFS_CFG_FIRST);

    // ******************************
    // configuration check on the selected page
    // ******************************
    jrx_pkg::jrx_cfg_t cp;
    logic [4:0] c_l;
    logic [4:0] c_f;
    logic [4:0] c_m;
    logic [4:0] c_s;
    logic [1:0] mm;
    logic [4:0] cfg_err;
    logic [7:0] csum;
    assign cp = cfg_reg[page_reg];
    assign c_l = 5'(cp[jrx_pkg::CW_L][4:0] + 5'd1); // RULE20
    assign c_f = 5'(cp[jrx_pkg::CW_F][4:0] + 5'd1);
    assign c_m = 5'(cp[jrx_pkg::CW_M][4:0] + 5'd1);
    assign c_s = 5'(cp[jrx_pkg::CW_S][4:0] + 5'd1);
    assign mm = jrx_pkg::mode_match(c_l, c_m, c_s, c_f, dual); // RULE1 RULE2
    assign cfg_err[0] = cp[jrx_pkg::CW_HD][7] != (c_f == 5'd1); // RULE3
    assign cfg_err[1] = 5'(cp[jrx_pkg::CW_N][4:0] + 5'd1) != jrx_pkg::SAMPLE_BITS
        || 5'(cp[jrx_pkg::CW_NP][4:0] + 5'd1) != jrx_pkg::SAMPLE_BITS; // RULE4
    assign cfg_err[2] = 5'(cp[jrx_pkg::CW_K][4:0] + 5'd1) != jrx_pkg::K_LONG
        && (mm[1] || 5'(cp[jrx_pkg::CW_K][4:0] + 5'd1) != jrx_pkg::K_SHORT); // RULE5
    assign cfg_err[3] = !mm[0];
    assign cfg_err[4] = dual && cfg_reg[0] != cfg_reg[1]; // RULE7
    assign csum = sum_method ? jrx_pkg::reg_sum(cp) : jrx_pkg::field_sum(cp); // RULE13 RULE14 RULE15

    // ******************************
    // sync machine
    // ******************************
    typedef enum logic [1:0] {JRX_IDLE, JRX_ENABLED, JRX_ARMED, JRX_LOCKED} jrx_sync_t;
    jrx_sync_t sync_reg;
    jrx_sync_t sync_next;
    logic [2:0] sysref_sync_reg;
    logic sysref_rise;
    logic lock_event;
    // sysref comes from outside, two flops before the edge detector looks at it
    assign sysref_rise = sysref_sync_reg[1] && !sysref_sync_reg[2];
    always_comb begin
        sync_next = sync_reg;
        case (sync_reg)
            JRX_IDLE: begin
                if (sync_ctrl_reg[jrx_pkg::SYNC_EN_BIT]) begin
                    sync_next = JRX_ENABLED; // RULE21
                end
            end
            JRX_ENABLED: begin
                if (sync_ctrl_reg[jrx_pkg::SYNC_ARM_BIT]) begin
                    sync_next = JRX_ARMED; // RULE21
                end
            end
            JRX_ARMED: begin
                // subclass 0 aligns to the internal clock, subclass 1 waits for sysref
                if (subclass_reg == 3'h0 || sysref_rise) begin
                    sync_next = JRX_LOCKED; // RULE17
                end
            end
            JRX_LOCKED: sync_next = JRX_LOCKED;
            default: sync_next = JRX_IDLE;
        endcase
        if (!sync_ctrl_reg[jrx_pkg::SYNC_EN_BIT]) begin
            sync_next = JRX_IDLE;
        end
    end
    assign lock_event = sync_reg == JRX_ARMED && sync_next == JRX_LOCKED;

    // register writes; a one-shot lock drops the arm bit unless software writes it in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            pwdn_reg <= 8'h00;
            link_ctrl_reg <= 8'h00;
            subclass_reg <= 3'h0;
            sync_ctrl_reg <= 8'h00;
            page_reg <= 1'b0;
            lane_en_reg <= 8'h00;
            lane_dsk_reg <= 8'h00;
            link_rst_reg <= 2'b00;
            cfg_reg[0] <= '0;
            cfg_reg[1] <= '0;
            sync_reg <= JRX_IDLE;
            sysref_sync_reg <= 3'b000;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            sync_reg <= sync_next;
            sysref_sync_reg <= {sysref_sync_reg[1:0], link.sysref};
            if (lock_event && sync_ctrl_reg[jrx_pkg::SYNC_ONESHOT_BIT]) begin
                sync_ctrl_reg[jrx_pkg::SYNC_ARM_BIT] <= 1'b0;
            end
            if (wr_go) begin
                case (idx)
                    jrx_pkg::OFS_PWDN: pwdn_reg <= wbyte; // RULE12
                    jrx_pkg::OFS_LINK_CTRL: link_ctrl_reg <= wbyte & 8'h4B;
                    jrx_pkg::OFS_SUBCLASS: subclass_reg <= wbyte[2:0];
                    jrx_pkg::OFS_SYNC_CTRL: sync_ctrl_reg <= wbyte; // RULE21
                    jrx_pkg::OFS_PAGE: page_reg <= wbyte[0];
                    jrx_pkg::OFS_LANE_EN: lane_en_reg <= wbyte; // RULE11
                    jrx_pkg::OFS_LANE_DSK: lane_dsk_reg <= wbyte; // RULE11
                    jrx_pkg::OFS_LINK_RST: link_rst_reg <= wbyte[1:0];
                    default: begin
                        if (cfg_hit) begin
                            cfg_reg[page_reg][cfg_idx] <= wbyte; // RULE10
                        end
                    end
                endcase
            end
        end
    end

    // read mux, loaded in the wait cycle so data stands when waitrequest drops
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            jrx_pkg::OFS_PWDN: rd_byte = pwdn_reg;
            jrx_pkg::OFS_LINK_CTRL: rd_byte = link_ctrl_reg;
            jrx_pkg::OFS_SUBCLASS: rd_byte = {5'h00, subclass_reg};
            jrx_pkg::OFS_SYNC_CTRL: rd_byte = sync_ctrl_reg;
            jrx_pkg::OFS_SYNC_STAT: rd_byte[jrx_pkg::STAT_LOCK_BIT] = sync_reg == JRX_LOCKED; // RULE18
            jrx_pkg::OFS_PAGE: rd_byte = {7'h00, page_reg};
            jrx_pkg::OFS_LANE_EN: rd_byte = lane_en_reg;
            jrx_pkg::OFS_LANE_DSK: rd_byte = lane_dsk_reg;
            jrx_pkg::OFS_CSUM: rd_byte = csum;
            jrx_pkg::OFS_LINK_RST: rd_byte = {6'h00, link_rst_reg};
            jrx_pkg::OFS_CFG_ERR: rd_byte = {3'h0, cfg_err};
            default: rd_byte = cfg_hit ? cp[cfg_idx] : 8'h00; // RULE10
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else if (rd_go) begin
            avs_readdata <= {24'h0, rd_byte};
        end
    end

    // ******************************
    // lane data path
    // ******************************
    logic [LANES-1:0] lane_live;
    logic [LANES-1:0] lane_link;
    logic [1:0] link_up;
    logic [LANES-1:0][14:0] st_reg;
    logic [LANES-1:0][14:0] st_next;
    logic [LANES-1:0][7:0] oct_next;
    logic scr_on;
    assign scr_on = cp[jrx_pkg::CW_L][7];
    // link up when activated, out of its own reset and locked
    assign link_up[0] = link_on[0] && !link_rst_reg[0] && sync_reg == JRX_LOCKED; // RULE6
    assign link_up[1] = link_on[1] && !link_rst_reg[1] && sync_reg == JRX_LOCKED; // RULE6
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign lane_link[g] = dual && g >= LANES / 2;
            assign lane_live[g] = lane_en_reg[g] && !pwdn_reg[g] && link_up[lane_link[g]]; // RULE11 RULE12
        end
    endgenerate
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            st_next[i] = st_reg[i];
            oct_next[i] = jrx_pkg::RESET_BYTE;
            if (!lane_live[i] || !link.lane_valid) begin
                st_next[i] = lane_live[i] ? st_reg[i] : 15'h0000;
            end else if (scr_on) begin
                {st_next[i], oct_next[i]} = jrx_pkg::scr_step(st_reg[i], link.lane_octet[i], 1'b1); // RULE9 RULE22
            end else begin
                oct_next[i] = link.lane_octet[i]; // RULE9
            end
        end
    end
    // a link is valid only once every deskewed lane of it is live
    logic [1:0] valid_next;
    assign valid_next[0] = link_up[0] && link.lane_valid
        && ((lane_live | ~(lane_dsk_reg & ~lane_link)) == {LANES{1'b1}});
    assign valid_next[1] = link_up[1] && link.lane_valid
        && ((lane_live | ~(lane_dsk_reg & lane_link)) == {LANES{1'b1}});
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            rx_octet <= '0;
            rx_valid <= 2'b00;
            link.sync_n <= 2'b00;
        end else begin
            st_reg <= st_next;
            rx_octet <= oct_next;
            rx_valid <= valid_next;
            link.sync_n <= link_up; // RULE6
        end
    end
endmodule

// >>> hw/jrx_tx.sv
// transmitter end: lane framing, scrambling and its own configuration sum
`timescale 1ns/1ps
module jrx_tx #(parameter int LANES = 8) (
    input wire logic clk,
    input wire logic resetn,
    jrx_link_if.tx_end link,
    input wire logic [3:0] mode,
    input wire logic dual,
    input wire logic k_short,
    input wire logic scramble_en,
    input wire logic sum_method,
    input wire logic [2:0] subclass,
    input wire logic [2:0] version,
    input wire logic [15:0] data_rate,
    input wire logic [LANES-1:0][7:0] sample_in,
    output logic sample_ready,
    input wire logic sysref_req,
    output logic [31:0] lane_rate_out,
    output logic [7:0] cfg_sum_out
);
    // ******************************
    // configuration as the far end expects it
    // ******************************
    jrx_pkg::jrx_mode_t mp;
    jrx_pkg::jrx_cfg_t cfg;
    logic [LANES-1:0] lane_used;
    logic [LANES-1:0] lane_live;
    assign mp = jrx_pkg::mode_params(mode, dual);
    // counts go out as value minus one, flags beside them
    always_comb begin
        cfg = '0;
        cfg[jrx_pkg::CW_L] = {scramble_en, 2'b00, 5'(mp.l - 5'd1)}; // RULE20 RULE8
        cfg[jrx_pkg::CW_F] = {3'h0, 5'(mp.f - 5'd1)};
        cfg[jrx_pkg::CW_K] = {3'h0, k_short ? 5'(jrx_pkg::K_SHORT - 5'd1) : 5'h1F};
        cfg[jrx_pkg::CW_M] = {3'h0, 5'(mp.m - 5'd1)};
        cfg[jrx_pkg::CW_N] = {3'h0, 5'(jrx_pkg::SAMPLE_BITS - 5'd1)}; // RULE4
        cfg[jrx_pkg::CW_NP] = {subclass, 5'(jrx_pkg::SAMPLE_BITS - 5'd1)};
        cfg[jrx_pkg::CW_S] = {version, 5'(mp.s - 5'd1)};
        cfg[jrx_pkg::CW_HD] = {(mp.f == 5'd1), 7'h00}; // RULE3
    end

    // lanes of link 0 from lane 0 up, link 1 from the upper half in dual mode
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_used
            assign lane_used[g] = (g < LANES / 2 || !dual) ? (5'(g % (LANES / 2) + (dual ? 0 : g / (LANES / 2) * 4))
                < mp.l) : (5'(g - LANES / 2) < mp.l); // RULE1 RULE2
            assign lane_live[g] = lane_used[g] && link.sync_n[(dual && g >= LANES / 2) ? 1 : 0] == 1'b1;
        end
    endgenerate

    // data is only taken while every used lane is past sync
    assign sample_ready = mp.ok && ((lane_live | ~lane_used) == {LANES{1'b1}});

    // ******************************
    // lane octets
    // ******************************
    logic [LANES-1:0][14:0] st_reg;
    logic [LANES-1:0][14:0] st_next;
    logic [LANES-1:0][7:0] oct_next;
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            st_next[i] = st_reg[i];
            oct_next[i] = jrx_pkg::RESET_BYTE;
            if (!lane_live[i]) begin
                oct_next[i] = lane_used[i] ? jrx_pkg::K28_5 : jrx_pkg::RESET_BYTE; // comma stays unscrambled
            end else if (scramble_en) begin
                {st_next[i], oct_next[i]} = jrx_pkg::scr_step(st_reg[i], sample_in[i], 1'b0);
            end else begin
                oct_next[i] = sample_in[i];
            end
        end
    end

    // registered outputs toward the link and the user
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            link.lane_octet <= '0;
            link.lane_valid <= 1'b0;
            link.sysref <= 1'b0;
            lane_rate_out <= 32'h0;
            cfg_sum_out <= 8'h00;
        end else begin
            st_reg <= st_next;
            link.lane_octet <= oct_next;
            link.lane_valid <= mp.ok;
            link.sysref <= sysref_req;
            lane_rate_out <= jrx_pkg::lane_rate(data_rate, mp.m, mp.l); // RULE16
            cfg_sum_out <= sum_method ? jrx_pkg::reg_sum(cfg) : jrx_pkg::field_sum(cfg); // RULE13 RULE14 RULE15
        end
    end
endmodule
